// File: src/fscm_f2i.sv
`timescale 1ns/1ps
// single precision to 32-bit integer with directed rounding
module fscm_f2i import fscm_pkg::*; (
  input wire logic [31:0] src,
  input wire fscm_rm_e rmode,
  input wire logic to_unsigned,
  output logic [31:0] result
);
  logic sgn;
  logic [7:0] e;
  logic [55:0] fix;
  logic [31:0] ip;
  logic [23:0] fr;
  logic g;
  logic st;
  logic inc;
  logic [32:0] mag;
  logic [33:0] sval;
  always_comb begin
    sgn = src[31];
    e = src[30:23];
    fix = '0;
    ip = '0;
    fr = '0;
    inc = 1'b0;
    // mantissa placed with 24 fraction bits; exponents >= 158 saturate below, except NaN which gives 0
    if (e >= 8'd103 && e < 8'd158) begin
      fix = 56'({1'b1, src[22:0]});
      // split shift keeps the widest value inside the 56-bit window
      if (e >= 8'd126) fix = fix << (e - 8'd126);
      else fix = fix >> (8'd126 - e);
    end else if (e < 8'd103 && src[30:0] != 31'd0) begin
      // tiny values and subnormals only leave a sticky bit
      fix = 56'd1;
    end
    ip = fix[55:24];
    fr = fix[23:0];
    g = fr[23];
    st = |fr[22:0];
    case (rmode)
      FSCM_RM_AWAY: inc = g;
      FSCM_RM_NEAR_EVEN: inc = g & (st | ip[0]);
      FSCM_RM_PLUS: inc = ~sgn & (g | st);
      FSCM_RM_MINUS: inc = sgn & (g | st);
      default: inc = 1'b0;
    endcase
    mag = {1'b0, ip} + 33'(inc);
    sval = sgn ? -{1'b0, mag} : {1'b0, mag};
    if (e == 8'hFF && src[22:0] != 23'd0) begin
      result = 32'h00000000;
    end else if (to_unsigned) begin
      if (sval[33]) result = 32'h00000000;
      else if (e >= 8'd158 || mag[32]) result = FSCM_U32_MAX;
      else result = mag[31:0];
    end else if (e >= 8'd158 || mag > 33'h080000000 ||
                 (!sgn && mag > 33'h07FFFFFFF)) begin
      result = sgn ? FSCM_S32_MIN : FSCM_S32_MAX;
    end else begin
      result = sval[31:0];
    end
  end
endmodule

// File: src/fscm_pkg.sv
// shared constants and types for the fp select/convert/minmax unit
package fscm_pkg;
  typedef enum logic [3:0] {
    FSCM_OP_SUB, FSCM_OP_SEL, FSCM_OP_CVT_A, FSCM_OP_CVT_M, FSCM_OP_CVT_N,
    FSCM_OP_CVT_P, FSCM_OP_H2S, FSCM_OP_S2H, FSCM_OP_MAX, FSCM_OP_MIN
  } fscm_op_e;
  typedef enum logic [1:0] {FSCM_CC_GE, FSCM_CC_GT, FSCM_CC_EQ, FSCM_CC_VS} fscm_cc_e;
  typedef enum logic [1:0] {FSCM_RM_NEAR_EVEN, FSCM_RM_PLUS, FSCM_RM_MINUS, FSCM_RM_AWAY} fscm_rm_e;
  localparam int FSCM_FLAG_N = 3;
  localparam int FSCM_FLAG_Z = 2;
  localparam int FSCM_FLAG_C = 1;
  localparam int FSCM_FLAG_V = 0;
  localparam int FSCM_HALF_LO = 0;
  localparam int FSCM_HALF_HI = 16;
  localparam logic [31:0] FSCM_QNAN = 32'h7FC00000;
  localparam logic [31:0] FSCM_RESULT_RST = 32'h00000000;
  localparam logic [31:0] FSCM_S32_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] FSCM_S32_MIN = 32'h80000000;
  localparam logic [31:0] FSCM_U32_MAX = 32'hFFFFFFFF;
endpackage

// File: src/fscm_unit.sv
`timescale 1ns/1ps
// fp subtract, select, directed convert, half convert and max/min number unit
module fscm_unit import fscm_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic op_valid,
  input wire fscm_op_e op,
  input wire fscm_cc_e sel_cond,
  input wire logic cvt_unsigned,
  input wire logic half_top,
  input wire logic [3:0] app_status_flags_reg,
  input wire logic [31:0] first_src_fp_reg,
  input wire logic [31:0] second_src_fp_reg,
  input wire logic [31:0] dest_old,
  output logic [31:0] dest_fp_reg,
  output logic result_valid
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_nan(input logic [31:0] x);
    is_nan = (x[30:23] == 8'hFF) && (x[22:0] != 23'd0);
  endfunction
  function automatic logic is_snan(input logic [31:0] x);
    is_snan = is_nan(x) && !x[22];
  endfunction
  // a < b for non-NaN values, -0 treated below +0
  function automatic logic f_less(input logic [31:0] a, input logic [31:0] b);
    if (a[31] != b[31]) f_less = a[31];
    else if (a[31]) f_less = a[30:0] > b[30:0];
    else f_less = a[30:0] < b[30:0];
  endfunction
  // ----------------------------------------
  // subtract, round to nearest even
  // ----------------------------------------
  logic [31:0] sub_res;
  logic [31:0] bn;
  logic [31:0] big;
  logic [31:0] sml;
  logic [7:0] eb;
  logic [7:0] es;
  logic [7:0] sh;
  logic [27:0] mb;
  logic [27:0] ms;
  logic [28:0] sum;
  logic stk;
  logic [4:0] lz;
  logic [9:0] er;
  logic [27:0] nm;
  logic [24:0] rm;
  always_comb begin
    bn = {~second_src_fp_reg[31], second_src_fp_reg[30:0]};
    big = (first_src_fp_reg[30:0] >= bn[30:0]) ? first_src_fp_reg : bn;
    sml = (first_src_fp_reg[30:0] >= bn[30:0]) ? bn : first_src_fp_reg;
    eb = (big[30:23] == 8'd0) ? 8'd1 : big[30:23];
    es = (sml[30:23] == 8'd0) ? 8'd1 : sml[30:23];
    mb = {1'b0, big[30:23] != 8'd0, big[22:0], 3'b000};
    ms = {1'b0, sml[30:23] != 8'd0, sml[22:0], 3'b000};
    sh = eb - es;
    stk = 1'b0;
    if (sh > 8'd27) begin
      stk = |ms;
      ms = '0;
    end else begin
      for (int i = 0; i < 28; i++) if (i < sh && ms[i]) stk = 1'b1;
      ms = ms >> sh;
    end
    ms[0] = ms[0] | stk;
    sum = (big[31] == sml[31]) ? {1'b0, mb} + {1'b0, ms} : {1'b0, mb} - {1'b0, ms};
    lz = 5'd0;
    // highest set bit wins, giving the leading zeros below bit 26
    for (int i = 0; i < 27; i++) if (sum[i]) lz = 5'(26 - i);
    if (sum[27]) begin
      nm = {1'b0, sum[27:2], sum[1] | sum[0]};
      er = {2'b00, eb} + 10'd1;
    end else if ({2'b00, eb} > {5'd0, lz}) begin
      nm = sum[27:0] << lz;
      er = {2'b00, eb} - {5'd0, lz};
    end else begin
      nm = sum[27:0] << (eb - 8'd1);
      // subnormal keeps the minimum exponent in case rounding makes it normal
      er = 10'd1;
    end
    rm = {1'b0, nm[26:3]} + 25'(nm[2] & (nm[1] | nm[0] | nm[3]));
    if (rm[24]) er = er + 10'd1;
    if (is_nan(first_src_fp_reg) || is_nan(second_src_fp_reg) ||
        (first_src_fp_reg[30:0] == 31'h7F800000 && bn[30:0] == 31'h7F800000 &&
         first_src_fp_reg[31] != bn[31])) sub_res = FSCM_QNAN;
    else if (big[30:23] == 8'hFF) sub_res = big;
    else if (sum == '0) sub_res = {big[31] & sml[31], 31'd0};
    else if (er >= 10'd255) sub_res = {big[31], 31'h7F800000};
    else sub_res = {big[31], ((rm[23] | rm[24]) ? er[7:0] : 8'd0), rm[22:0]};
  end
  // ----------------------------------------
  // select, convert, max/min
  // ----------------------------------------
  logic cond_ok;
  logic [31:0] cvt_int;
  fscm_rm_e rmode;
  always_comb begin
    case (op)
      FSCM_OP_CVT_A: rmode = FSCM_RM_AWAY;
      FSCM_OP_CVT_N: rmode = FSCM_RM_NEAR_EVEN;
      FSCM_OP_CVT_P: rmode = FSCM_RM_PLUS;
      FSCM_OP_CVT_M: rmode = FSCM_RM_MINUS;
      default: rmode = FSCM_RM_NEAR_EVEN;
    endcase
  end
  fscm_f2i u_f2i (
    .src(second_src_fp_reg),
    .rmode(rmode),
    .to_unsigned(cvt_unsigned),
    .result(cvt_int)
  );
  // only integer flags are consulted, fp compare state never reaches here
  always_comb begin
    case (sel_cond)
      FSCM_CC_GE: cond_ok = app_status_flags_reg[FSCM_FLAG_N] == app_status_flags_reg[FSCM_FLAG_V];
      FSCM_CC_GT: cond_ok = !app_status_flags_reg[FSCM_FLAG_Z] &&
                            app_status_flags_reg[FSCM_FLAG_N] == app_status_flags_reg[FSCM_FLAG_V];
      FSCM_CC_EQ: cond_ok = app_status_flags_reg[FSCM_FLAG_Z];
      FSCM_CC_VS: cond_ok = app_status_flags_reg[FSCM_FLAG_V];
      default: cond_ok = 1'b0;
    endcase
  end
  logic [15:0] h_in;
  logic [31:0] h2s;
  logic [15:0] s2h;
  logic [4:0] hlz;
  logic [9:0] hm;
  logic [8:0] he;
  logic [24:0] hs;
  logic [11:0] hr;
  logic [7:0] hsh;
  always_comb begin
    // half to single is exact, so no rounding step exists
    h_in = half_top ? second_src_fp_reg[FSCM_HALF_HI +: 16] : second_src_fp_reg[FSCM_HALF_LO +: 16];
    hlz = 5'd0;
    for (int i = 9; i >= 0; i--) if (h_in[i] && hlz == 5'd0) hlz = 5'(10 - i);
    hm = 10'(h_in[9:0] << hlz);
    if (h_in[14:10] == 5'h1F) h2s = {h_in[15], 8'hFF, h_in[9:0] | {h_in[9:0] != 0, 9'd0}, 13'd0};
    else if (h_in[14:10] != 5'd0) h2s = {h_in[15], 8'(h_in[14:10]) + 8'd112, h_in[9:0], 13'd0};
    else if (h_in[9:0] == 10'd0) h2s = {h_in[15], 31'd0};
    else h2s = {h_in[15], 8'd113 - 8'(hlz), hm, 13'd0};
    // single to half, single rounding straight to nearest even
    he = {1'b0, second_src_fp_reg[30:23]} - 9'd112;
    hs = {1'b1, second_src_fp_reg[22:0], 1'b0};
    hsh = 8'd113 - second_src_fp_reg[30:23];
    if (second_src_fp_reg[30:23] < 8'd113) begin
      // bits shifted out still count towards the sticky bit
      hs = (hsh > 8'd24) ? 25'd1 : (hs >> hsh) | 25'(|(hs & ~({25{1'b1}} << hsh)));
      he = 9'd0;
    end
    hr = {1'b0, hs[24:14]} + 12'(hs[13] & (|hs[12:0] | hs[14]));
    if (is_nan(second_src_fp_reg)) s2h = {second_src_fp_reg[31], 5'h1F, 1'b1, second_src_fp_reg[21:13]};
    else if (second_src_fp_reg[30:23] == 8'hFF || (he >= 9'd31 && !he[8]) ||
             (he == 9'd30 && hr[11])) s2h = {second_src_fp_reg[31], 15'h7C00};
    else if (he == 9'd0) s2h = {second_src_fp_reg[31], 4'd0, hr[10:0]};
    else s2h = {second_src_fp_reg[31], he[4:0] + 5'(hr[11]), hr[9:0]};
  end
  logic [31:0] mm_res;
  logic a_lt_b;
  always_comb begin
    a_lt_b = f_less(first_src_fp_reg, second_src_fp_reg);
    // a quiet NaN loses to a number, a signalling NaN yields the default NaN
    if (is_snan(first_src_fp_reg) || is_snan(second_src_fp_reg)) mm_res = FSCM_QNAN;
    else if (is_nan(first_src_fp_reg) && is_nan(second_src_fp_reg)) mm_res = FSCM_QNAN;
    else if (is_nan(first_src_fp_reg)) mm_res = second_src_fp_reg;
    else if (is_nan(second_src_fp_reg)) mm_res = first_src_fp_reg;
    else if (op == FSCM_OP_MAX) mm_res = a_lt_b ? second_src_fp_reg : first_src_fp_reg;
    else mm_res = a_lt_b ? first_src_fp_reg : second_src_fp_reg;
  end
  // ----------------------------------------
  // result register
  // ----------------------------------------
  logic [31:0] next_dest_fp_reg;
  logic next_result_valid;
  always_comb begin
    next_dest_fp_reg = dest_fp_reg;
    next_result_valid = op_valid;
    if (op_valid) begin
      case (op)
        FSCM_OP_SUB: next_dest_fp_reg = sub_res;
        FSCM_OP_SEL: next_dest_fp_reg = cond_ok ? first_src_fp_reg : second_src_fp_reg;
        FSCM_OP_CVT_A, FSCM_OP_CVT_M, FSCM_OP_CVT_N, FSCM_OP_CVT_P: next_dest_fp_reg = cvt_int;
        FSCM_OP_H2S: next_dest_fp_reg = h2s;
        FSCM_OP_S2H: next_dest_fp_reg = half_top ? {s2h, dest_old[15:0]} : {dest_old[31:16], s2h};
        FSCM_OP_MAX, FSCM_OP_MIN: next_dest_fp_reg = mm_res;
        default: next_dest_fp_reg = dest_fp_reg;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dest_fp_reg <= FSCM_RESULT_RST;
      result_valid <= 1'b0;
    end else if (ce) begin
      dest_fp_reg <= next_dest_fp_reg;
      result_valid <= next_result_valid;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_sel_first: assert property (ce && op_valid && op == FSCM_OP_SEL && cond_ok |=> dest_fp_reg == $past(first_src_fp_reg)) else $error("select first wrong");
  a_sel_second: assert property (ce && op_valid && op == FSCM_OP_SEL && !cond_ok |=> dest_fp_reg == $past(second_src_fp_reg)) else $error("select second wrong");
  a_sel_eq_flag: assert property (ce && op_valid && op == FSCM_OP_SEL && sel_cond == FSCM_CC_EQ |=> dest_fp_reg == ($past(app_status_flags_reg[2]) ? $past(first_src_fp_reg) : $past(second_src_fp_reg))) else $error("eq select wrong");
  a_sel_vs_flag: assert property (ce && op_valid && op == FSCM_OP_SEL && sel_cond == FSCM_CC_VS |=> dest_fp_reg == ($past(app_status_flags_reg[0]) ? $past(first_src_fp_reg) : $past(second_src_fp_reg))) else $error("vs select wrong");
  a_s2h_keep_lo: assert property (ce && op_valid && op == FSCM_OP_S2H && half_top |=> dest_fp_reg[15:0] == $past(dest_old[15:0])) else $error("low half not kept");
  a_s2h_keep_hi: assert property (ce && op_valid && op == FSCM_OP_S2H && !half_top |=> dest_fp_reg[31:16] == $past(dest_old[31:16])) else $error("high half not kept");
  a_max_larger: assert property (ce && op_valid && op == FSCM_OP_MAX && !is_nan(first_src_fp_reg) && !is_nan(second_src_fp_reg) |=> !f_less(dest_fp_reg, $past(first_src_fp_reg)) && !f_less(dest_fp_reg, $past(second_src_fp_reg))) else $error("max not larger");
  a_min_qnan: assert property (ce && op_valid && op == FSCM_OP_MIN && is_nan(first_src_fp_reg) && !is_snan(first_src_fp_reg) && !is_nan(second_src_fp_reg) |=> dest_fp_reg == $past(second_src_fp_reg)) else $error("minnum nan wrong");
  a_valid_follow: assert property (ce |=> result_valid == $past(op_valid)) else $error("valid not following");
  a_freeze: assert property (!ce |=> $stable(dest_fp_reg) && $stable(result_valid)) else $error("state moved with ce low");
endmodule

// File: tb/fscm_issue.sv
// issue-side model presenting decoded operations to the unit
`timescale 1ns/1ps
module fscm_issue import fscm_pkg::*; (
  input wire logic clk,
  output logic op_valid,
  output fscm_op_e op,
  output fscm_cc_e sel_cond,
  output logic cvt_unsigned,
  output logic half_top,
  output logic [3:0] flags,
  output logic [31:0] src_a,
  output logic [31:0] src_b,
  output logic [31:0] old
);
  initial begin
    op_valid = 1'b0;
    op = FSCM_OP_SUB;
    sel_cond = FSCM_CC_GE;
    cvt_unsigned = 1'b0;
    half_top = 1'b0;
    flags = 4'h0;
    src_a = 32'h0;
    src_b = 32'h0;
    old = 32'h0;
  end
  // select is always issued bare, never under a predication block
  task automatic issue(input fscm_op_e o, input fscm_cc_e cc, input logic [3:0] fl,
      input logic uns, input logic top, input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] d);
    @(posedge clk);
    op_valid <= 1'b1;
    op <= o;
    sel_cond <= cc;
    cvt_unsigned <= uns;
    half_top <= top;
    flags <= fl;
    src_a <= a;
    src_b <= b;
    old <= d;
    @(posedge clk);
    op_valid <= 1'b0;
    // operands inverted once released, so a late sample cannot match
    src_a <= ~a;
    src_b <= ~b;
    old <= ~d;
  endtask
endmodule

// File: tb/fscm_unit_bench.sv
// self-checking bench for the fp select/convert/minmax unit
`timescale 1ns/1ps
module fscm_unit_bench import fscm_pkg::*;;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic op_valid, cvt_unsigned, half_top, result_valid;
  fscm_op_e op;
  fscm_cc_e sel_cond;
  logic [3:0] flags;
  logic [31:0] src_a, src_b, old, dest_fp_reg;
  int err_total = 0;
  int samples_checked = 0;
  always #12.5 clk = ~clk;
  fscm_issue issuer (.clk(clk), .op_valid(op_valid), .op(op), .sel_cond(sel_cond),
    .cvt_unsigned(cvt_unsigned), .half_top(half_top), .flags(flags), .src_a(src_a),
    .src_b(src_b), .old(old));
  // clock enable driven by the bench so that freezing is exercised
  fscm_unit dut (.clk(clk), .resetn(resetn), .ce(ce), .op_valid(op_valid), .op(op),
    .sel_cond(sel_cond), .cvt_unsigned(cvt_unsigned), .half_top(half_top),
    .app_status_flags_reg(flags), .first_src_fp_reg(src_a), .second_src_fp_reg(src_b),
    .dest_old(old), .dest_fp_reg(dest_fp_reg), .result_valid(result_valid));
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic run(input fscm_op_e o, input fscm_cc_e cc, input logic [3:0] fl,
      input logic uns, input logic top, input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] d, input logic [31:0] exp);
    int n;
    issuer.issue(o, cc, fl, uns, top, a, b, d);
    n = 0;
    @(negedge clk);
    while (result_valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (n == 4) begin
      err_total++;
      $display("FAIL %0t no result", $time);
      close_out();
    end else begin
      chk(dest_fp_reg, exp, o.name());
      @(negedge clk);
      chk({31'h0, result_valid}, 32'h0, "pulse");
    end
  endtask
  function automatic logic holds(input fscm_cc_e cc, input logic [3:0] f);
    case (cc)
      FSCM_CC_GE: return f[FSCM_FLAG_N] == f[FSCM_FLAG_V];
      FSCM_CC_GT: return !f[FSCM_FLAG_Z] && f[FSCM_FLAG_N] == f[FSCM_FLAG_V];
      FSCM_CC_EQ: return f[FSCM_FLAG_Z];
      default: return f[FSCM_FLAG_V];
    endcase
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_sub();
    run(FSCM_OP_SUB, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h40400000, 32'h3F800000, 32'h0,
      32'h40000000);
    run(FSCM_OP_SUB, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h3F800000, 32'h40400000, 32'h0,
      32'hC0000000);
    run(FSCM_OP_SUB, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h3FFFFFFF, 32'hB3800000, 32'h0,
      32'h40000000);
  endtask
  task automatic t_sel();
    fscm_cc_e cc;
    for (int i = 0; i < 64; i++) begin
      cc = fscm_cc_e'(i[5:4]);
      run(FSCM_OP_SEL, cc, i[3:0], 1'b0, 1'b0, 32'h11111111, 32'h22222222, 32'h0,
        holds(cc, i[3:0]) ? 32'h11111111 : 32'h22222222);
    end
  endtask
  task automatic t_cvt();
    fscm_op_e ops[4] = '{FSCM_OP_CVT_A, FSCM_OP_CVT_N, FSCM_OP_CVT_P, FSCM_OP_CVT_M};
    logic [31:0] pos[4] = '{32'h3, 32'h2, 32'h3, 32'h2};
    logic [31:0] neg[4] = '{32'hFFFFFFFD, 32'hFFFFFFFE, 32'hFFFFFFFE, 32'hFFFFFFFD};
    for (int i = 0; i < 4; i++) begin
      run(ops[i], FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h0, 32'h40200000, 32'h0,
        pos[i]);
      run(ops[i], FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h0, 32'hC0200000, 32'h0,
        neg[i]);
      run(ops[i], FSCM_CC_GE, 4'h0, 1'b1, 1'b0, 32'h0, 32'h40200000, 32'h0,
        pos[i]);
    end
    run(FSCM_OP_CVT_N, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h0, 32'h447A0000, 32'h0,
      32'h000003E8);
    run(FSCM_OP_CVT_N, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h0, 32'h4F800000, 32'h0,
      FSCM_S32_MAX);
    run(FSCM_OP_CVT_N, FSCM_CC_GE, 4'h0, 1'b1, 1'b0, 32'h0, 32'hC0200000, 32'h0,
      32'h00000000);
  endtask
  task automatic t_half();
    run(FSCM_OP_H2S, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h0, 32'h12343C01, 32'h0,
      32'h3F802000);
    run(FSCM_OP_H2S, FSCM_CC_GE, 4'h0, 1'b0, 1'b1, 32'h0, 32'h3C011234, 32'h0,
      32'h3F802000);
    run(FSCM_OP_S2H, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h0, 32'h3F802000, 32'hABCD1234,
      32'hABCD3C01);
    run(FSCM_OP_S2H, FSCM_CC_GE, 4'h0, 1'b0, 1'b1, 32'h0, 32'h3F802000, 32'hABCD1234,
      32'h3C011234);
  endtask
  task automatic t_mm();
    run(FSCM_OP_MAX, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h3F800000, 32'hC0000000, 32'h0,
      32'h3F800000);
    run(FSCM_OP_MIN, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h3F800000, 32'hC0000000, 32'h0,
      32'hC0000000);
    run(FSCM_OP_MAX, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, FSCM_QNAN, 32'hC0000000, 32'h0,
      32'hC0000000);
    run(FSCM_OP_MIN, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h3F800000, FSCM_QNAN, 32'h0,
      32'h3F800000);
    run(FSCM_OP_MAX, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h80000000, 32'h0, 32'h0,
      32'h0);
    run(FSCM_OP_MIN, FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h0, 32'h80000000, 32'h0,
      32'h80000000);
    // undefined code keeps the destination but still pulses valid
    run(fscm_op_e'(4'hA), FSCM_CC_GE, 4'h0, 1'b0, 1'b0, 32'h1, 32'h2, 32'h0,
      32'h80000000);
  endtask
  task automatic t_freeze();
    logic [31:0] keep;
    keep = dest_fp_reg;
    @(posedge clk);
    ce <= 1'b0;
    issuer.issue(FSCM_OP_SEL, FSCM_CC_EQ, 4'h4, 1'b0, 1'b0, 32'h33333333, 32'h44444444,
      32'h0);
    @(negedge clk);
    chk(dest_fp_reg, keep, "freeze dest");
    chk({31'h0, result_valid}, 32'h0, "freeze valid");
    @(posedge clk);
    ce <= 1'b1;
    @(negedge clk);
    chk(dest_fp_reg, keep, "thaw dest");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk(dest_fp_reg, FSCM_RESULT_RST, "reset dest");
    chk({31'h0, result_valid}, 32'h0, "reset valid");
    @(posedge clk);
    resetn <= 1'b1;
    t_sub();
    t_sel();
    t_cvt();
    t_half();
    t_mm();
    t_freeze();
    close_out();
  end
endmodule
